// file: rcs_regs.svh
// Constants for the residual current sensor readout
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH
`define RCS_WORD_W        16
`define RCS_MID_SCALE     16'h8000
`define RCS_FRAME_BYTES   3'h5
`define RCS_FRAME_BITS    6'h28
`define RCS_CRC_INIT      8'hff
`define RCS_CRC_POLY      8'h07
`define RCS_CLK_HZ        125000000
`define RCS_FAULT_HZ      16000
`define RCS_FAULT_HALF    (`RCS_CLK_HZ / (2 * `RCS_FAULT_HZ))
`define RCS_START_MS      100
`define RCS_START_CYC     (`RCS_CLK_HZ / 1000 * `RCS_START_MS)
`define RCS_HA_SHIFT      13
`define RCS_HB_SHIFT      6
`define RCS_TEST_GAIN     10
`define RCS_ERR_ONES      16'hffc0
`define RCS_ERR_HW_BIT    3
`define RCS_ERR_OOR_BIT   1
`define RCS_ERR_CRIT_BIT  0
`endif

// file: rcs_pkg.sv
// Types shared by the residual current sensor readout
package rcs_pkg;
  typedef struct packed {
    logic [15:0] hb_word;
    logic [15:0] ha_word;
  } rcs_sample_type;
  typedef struct packed {
    logic over_current;
    logic critical;
    logic selftest_fail;
  } rcs_fault_type;
  typedef enum logic [2:0] {
    RCS_ST_START = 3'h1,
    RCS_ST_RUN   = 3'h2,
    RCS_ST_FAULT = 3'h4
  } rcs_state_type;
endpackage

// file: rcs_fifo.sv
// Sample FIFO between the filter and the serial port
`timescale 1ns/1ps
module rcs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  logic             push;
  logic             pop;
  assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign out_data  = mem[rd_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule

// file: rcs_readout.sv
// Residual current sensor digital output: SPI slave, bitstream, fault pin
`timescale 1ns/1ps
`include "rcs_regs.svh"
// Operation
// - Reset input active low holds logic
// - Select active low; respond only while low
// - Sigma-delta bitstream at 48 MHz on positive
// - Negative output is complement of positive
// - Frame carries two 16-bit measurement words
// - Accuracy word is low-pass of bandwidth word
// - Offset binary, zero at mid-scale 32768
// - Fault pin toggles; freezes on fault
// - Fault on over, critical, or self-test
// - Test coil current counts ten times
// - Nominal operation within 100 ms of reset
// - Healthy fault toggle between 11-21 kHz
// - Frame five bytes, MSB first, CRC last
module rcs_readout #(
  parameter int START_CYC = `RCS_START_CYC,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  input  wire logic                    clk_mod,
  input  wire logic                    spi_sclk,
  input  wire logic                    spi_select_n,
  output logic                         spi_miso,
  output logic                         spi_miso_oe,
  input  wire logic signed [15:0]      meas_in,
  input  wire logic                    meas_valid,
  input  wire logic signed [15:0]      test_coil_in,
  input  wire rcs_pkg::rcs_fault_type  fault_in,
  output logic                         mod_pos,
  output logic                         mod_neg,
  output logic                         fault_out,
  output logic                         ready
);
  import rcs_pkg::*;
  initial begin
    if (START_CYC < 1) $error("START_CYC must be positive");
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]     sel_sync_reg;
  logic [2:0]     sclk_sync_reg;
  logic           sel_n;
  logic           sclk_rise;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sel_sync_reg  <= 3'h7;
      sclk_sync_reg <= 3'h0;
    end else begin
      sel_sync_reg  <= {sel_sync_reg[1:0], spi_select_n};
      sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk};
    end
  end
  assign sel_n     = sel_sync_reg[1];
  assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] d;
    d = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      d = d[7] ? ((d << 1) ^ `RCS_CRC_POLY) : (d << 1);
    end
    return d;
  endfunction

  function automatic logic [15:0] to_offset_binary(input logic signed [15:0] v);
    return v ^ `RCS_MID_SCALE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  rcs_state_type   state_reg;
  logic [31:0]     start_cnt_reg;
  logic            fault_hold_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= RCS_ST_START;
      start_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        RCS_ST_START: begin
          if (start_cnt_reg == 32'(START_CYC - 1)) begin
            state_reg <= RCS_ST_RUN;
          end
          start_cnt_reg <= start_cnt_reg + 32'h1;
        end
        RCS_ST_RUN: begin
          if (fault_hold_reg) begin
            state_reg <= RCS_ST_FAULT;
          end
        end
        RCS_ST_FAULT: begin
          if (!fault_hold_reg) begin
            state_reg <= RCS_ST_RUN;
          end
        end
        default: state_reg <= RCS_ST_START;
      endcase
    end
  end

  // Self-test failure is sticky until reset; current faults follow the input
  logic selftest_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      selftest_reg   <= 1'b0;
      fault_hold_reg <= 1'b0;
    end else begin
      selftest_reg   <= selftest_reg || fault_in.selftest_fail;
      fault_hold_reg <= fault_in.over_current || fault_in.critical
                        || fault_in.selftest_fail || selftest_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Toggling fault pin; a frozen level tells the host something is wrong
  localparam int HALF = `RCS_FAULT_HALF;
  logic [15:0] tog_cnt_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tog_cnt_reg <= '0;
      fault_out   <= 1'b0;
    end else if (state_reg == RCS_ST_RUN && !fault_hold_reg) begin
      if (tog_cnt_reg == 16'(HALF - 1)) begin
        tog_cnt_reg <= '0;
        fault_out   <= !fault_out;
      end else begin
        tog_cnt_reg <= tog_cnt_reg + 16'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ready <= 1'b0;
    end else begin
      ready <= state_reg != RCS_ST_START;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement path: test coil has ten turns, so its current counts tenfold
  logic signed [17:0] sum_w;
  logic signed [15:0] hb_reg;
  logic signed [31:0] ha_acc_reg;
  logic signed [15:0] ha_w;
  logic               smp_valid_reg;
  assign sum_w = 18'(meas_in) + 18'(test_coil_in) * 18'(`RCS_TEST_GAIN);
  assign ha_w  = 16'(ha_acc_reg >>> `RCS_HA_SHIFT);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hb_reg        <= '0;
      ha_acc_reg    <= '0;
      smp_valid_reg <= 1'b0;
    end else begin
      smp_valid_reg <= meas_valid;
      if (meas_valid) begin
        hb_reg <= (sum_w > 18'sh07fff) ? 16'sh7fff : (sum_w < -18'sh08000) ? -16'sh8000 : 16'(sum_w);
        // One-pole filter; the shift sets the narrow bandwidth versus the raw word
        ha_acc_reg <= ha_acc_reg + 32'(hb_reg) - 32'(ha_w);
      end
    end
  end

  rcs_sample_type smp_w;
  rcs_sample_type fifo_out;
  logic           fifo_in_ready;
  logic           fifo_out_valid;
  logic           fifo_pop;
  logic [15:0]    err_word;
  always_comb begin
    err_word = `RCS_ERR_ONES;
    err_word[`RCS_ERR_HW_BIT]   = selftest_reg;
    err_word[`RCS_ERR_OOR_BIT]  = fault_in.over_current;
    err_word[`RCS_ERR_CRIT_BIT] = fault_in.critical;
    smp_w.hb_word = fault_hold_reg ? err_word : to_offset_binary(hb_reg);
    smp_w.ha_word = to_offset_binary(ha_w);
  end

  // A full FIFO drops the oldest unread sample and also loses the sample arriving in that cycle
  rcs_fifo #(.WIDTH($bits(rcs_sample_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_data   (smp_w),
    .in_valid  (smp_valid_reg && state_reg != RCS_ST_START),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop || !fifo_in_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // SPI mode 1: change on rising SCLK, host samples on falling
  logic [39:0]   shift_reg;
  logic [31:0]   cur_reg;
  logic [5:0]    bit_cnt_reg;
  rcs_sample_type last_reg;
  rcs_sample_type frame_w;
  logic          sel_d_reg;
  logic [7:0]    crc_w;
  // The sample popped at frame start goes out in this very frame, not the next one
  assign frame_w = fifo_pop ? fifo_out : last_reg;
  assign crc_w = crc8_step(crc8_step(crc8_step(crc8_step(`RCS_CRC_INIT,
                 frame_w[31:24]), frame_w[23:16]), frame_w[15:8]), frame_w[7:0]);
  assign fifo_pop = sel_d_reg && !sel_n && fifo_out_valid; // Frame start takes a fresh sample
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      last_reg <= {`RCS_MID_SCALE, `RCS_MID_SCALE};
      sel_d_reg <= 1'b1;
    end else begin
      sel_d_reg <= sel_n;
      if (fifo_pop) begin
        last_reg <= fifo_out;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (sel_n) begin
      spi_miso_oe <= 1'b0;
      bit_cnt_reg <= '0;
      shift_reg   <= {last_reg, crc_w};
    end else begin
      spi_miso_oe <= 1'b1;
      if (sel_d_reg) begin
        shift_reg <= {frame_w, crc_w};
      end else if (sclk_rise && bit_cnt_reg != `RCS_FRAME_BITS) begin
        spi_miso    <= shift_reg[39];
        shift_reg   <= {shift_reg[38:0], 1'b0};
        bit_cnt_reg <= bit_cnt_reg + 6'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulator input crosses as a word via a toggle handshake
  logic        mod_ack_reg;
  logic        req_tog_reg;
  logic [15:0] xfer_reg;
  logic [1:0]  ack_sync_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      req_tog_reg  <= 1'b0;
      xfer_reg     <= `RCS_MID_SCALE;
      ack_sync_reg <= 2'h0;
    end else begin
      ack_sync_reg <= {ack_sync_reg[0], mod_ack_reg};
      if (ack_sync_reg[1] == req_tog_reg) begin
        xfer_reg    <= smp_w.hb_word;
        req_tog_reg <= !req_tog_reg;
      end
    end
  end

  logic [2:0]  req_sync_reg;
  logic [15:0] mod_word_reg;
  logic [16:0] sd_acc_reg;
  logic        mrst_1_reg;
  logic        mrst_n;
  always_ff @(posedge clk_mod or negedge reset_n) begin
    if (!reset_n) begin
      mrst_1_reg <= 1'b0;
      mrst_n     <= 1'b0;
    end else begin
      mrst_1_reg <= 1'b1;
      mrst_n     <= mrst_1_reg;
    end
  end
  always_ff @(posedge clk_mod or negedge mrst_n) begin
    if (!mrst_n) begin
      req_sync_reg <= 3'h0;
      mod_ack_reg  <= 1'b0;
      mod_word_reg <= `RCS_MID_SCALE;
    end else begin
      req_sync_reg <= {req_sync_reg[1:0], req_tog_reg};
      if (req_sync_reg[2] != req_sync_reg[1]) begin
        mod_word_reg <= xfer_reg;
        mod_ack_reg  <= req_sync_reg[1];
      end
    end
  end
  // First-order modulator clocked at 48 MHz; ones density follows the word
  always_ff @(posedge clk_mod or negedge mrst_n) begin
    if (!mrst_n) begin
      sd_acc_reg <= '0;
      mod_pos    <= 1'b0;
      mod_neg    <= 1'b1;
    end else begin
      sd_acc_reg <= {1'b0, sd_acc_reg[15:0]} + {1'b0, mod_word_reg};
      mod_pos    <= sd_acc_reg[16];
      mod_neg    <= !sd_acc_reg[16];
    end
  end
endmodule

// file: rcs_readout_sva.sv
// Port checks for the sensor readout
`timescale 1ns/1ps
module rcs_readout_sva #(
  parameter int START_CYC = 100
) (
  input wire logic                   clk_sys,
  input wire logic                   reset_n,
  input wire logic                   clk_mod,
  input wire logic                   spi_select_n,
  input wire logic                   spi_miso_oe,
  input wire rcs_pkg::rcs_fault_type fault_in,
  input wire logic                   mod_pos,
  input wire logic                   mod_neg,
  input wire logic                   fault_out,
  input wire logic                   ready
);
  import rcs_pkg::*;
  logic [31:0] cnt_reg;
  logic [7:0]  fcnt_reg;
  logic [15:0] hcnt_reg;
  logic        ok_reg;
  logic        st_reg;
  logic        fq_reg;
  logic        healthy;
  // Self-test stays frozen until reset, so it spoils the healthy window too
  assign healthy = ready && (fault_in == 3'h0) && !st_reg;
  ////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) cnt_reg <= 32'h0;
    else if (cnt_reg < START_CYC + 8) cnt_reg <= cnt_reg + 32'h1;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) fcnt_reg <= 8'h0;
    else if (fault_in == 3'h0) fcnt_reg <= 8'h0;
    else if (fcnt_reg < 8'hff) fcnt_reg <= fcnt_reg + 8'h1;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hcnt_reg <= 16'h0;
      ok_reg   <= 1'b0;
      st_reg   <= 1'b0;
      fq_reg   <= 1'b0;
    end else begin
      st_reg <= st_reg | fault_in.selftest_fail;
      fq_reg <= fault_out;
      if (fault_out != fq_reg) begin
        hcnt_reg <= 16'h0;
        ok_reg   <= healthy;
      end else begin
        hcnt_reg <= hcnt_reg + 16'h1;
        if (!healthy) ok_reg <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////
  reset_release_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(reset_n) |-> !ready && !spi_miso_oe && !fault_out) else $error("outputs active at reset release");
  ready_early_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ready |-> cnt_reg >= START_CYC) else $error("ready too early");
  ready_late_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cnt_reg > START_CYC + 4 |-> ready) else $error("ready too late");
  mod_pair_a: assert property (@(posedge clk_mod) disable iff (!reset_n)
    mod_neg == !mod_pos) else $error("bitstream pair not complementary");
  oe_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    spi_select_n [*4] |-> !spi_miso_oe) else $error("miso driven while deselected");
  oe_on_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !spi_select_n [*4] |-> spi_miso_oe) else $error("miso not driven while selected");
  fault_freeze_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fcnt_reg >= 8'h10 |-> $stable(fault_out)) else $error("fault pin toggles during fault");
  toggle_slow_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ok_reg |-> hcnt_reg < 16'd5681) else $error("fault pin toggles too slowly");
  toggle_fast_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ok_reg && (fault_out != fq_reg) |-> hcnt_reg >= 16'd2975) else $error("fault pin toggles too fast");
  ready_c: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(ready));
  select_c: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(spi_miso_oe));
  freeze_c: cover property (@(posedge clk_sys) disable iff (!reset_n) fcnt_reg == 8'h10);
endmodule
bind rcs_readout rcs_readout_sva #(.START_CYC(START_CYC)) rcs_readout_sva_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .clk_mod(clk_mod), .spi_select_n(spi_select_n),
  .spi_miso_oe(spi_miso_oe), .fault_in(fault_in), .mod_pos(mod_pos), .mod_neg(mod_neg),
  .fault_out(fault_out), .ready(ready));

// file: rcs_host_model.sv
// Host SPI master model reading sensor frames
`timescale 1ns/1ps
module rcs_host_model (
  input  wire logic clk_sys,
  output logic      spi_sclk,
  output logic      spi_select_n,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe
);
  logic [39:0]        frame_reg = 40'h0;
  logic signed [16:0] offset_reg = 17'sh0;
  logic signed [16:0] comp_reg = 17'sh0;
  initial begin
    spi_sclk = 1'b0;
    spi_select_n = 1'b1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // One frame takes about 11 us, far above 8 kSa/s
  task automatic read_frame(input logic take_offset);
    spi_select_n = 1'b0;
    wait_n(13);
    for (int i = 39; i >= 0; i--) begin
      spi_sclk = 1'b1;
      wait_n(16);
      // A released line shows the inverse, never a stale value
      frame_reg[i] = spi_miso_oe ? spi_miso : ~spi_miso;
      spi_sclk = 1'b0;
      wait_n(16);
    end
    wait_n(13);
    spi_select_n = 1'b1;
    wait_n(26);
    if (take_offset) offset_reg = $signed({1'b0, frame_reg[23:8]}) - 17'sd32768;
    comp_reg = $signed({1'b0, frame_reg[39:24]}) - 17'sd32768 - offset_reg;
  endtask
endmodule

// file: tb.sv
// Self-checking bench for the sensor readout
`timescale 1ns/1ps
module tb;
  import rcs_pkg::*;
  localparam int START = 100;
  logic                 clk_sys, clk_mod, spi_sclk, spi_select_n, spi_miso, spi_miso_oe;
  logic                 reset_n = 1'b0;
  logic                 meas_valid = 1'b0;
  logic signed [15:0]   meas_in = 16'sh0;
  logic signed [15:0]   test_coil_in = 16'sh0;
  rcs_fault_type        fault_in = 3'h0;
  logic                 mod_pos, mod_neg, fault_out, ready;
  logic [15:0]          fexp [3] = '{16'hffc2, 16'hffc1, 16'hffc8};
  int                   err_count = 0;
  int                   checks_done = 0;
  rcs_readout #(.START_CYC(START)) rcs_readout_inst (.clk_sys(clk_sys), .reset_n(reset_n), .clk_mod(clk_mod),
    .spi_sclk(spi_sclk), .spi_select_n(spi_select_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .meas_in(meas_in), .meas_valid(meas_valid), .test_coil_in(test_coil_in), .fault_in(fault_in),
    .mod_pos(mod_pos), .mod_neg(mod_neg), .fault_out(fault_out), .ready(ready));
  rcs_host_model rcs_host_model_inst (.clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_select_n(spi_select_n),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    clk_mod = 1'b0;
    #1.7;
    forever #3 clk_mod = ~clk_mod;
  end
  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic results;
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_reset(input int n);
    int k;
    @(negedge clk_sys);
    reset_n = 1'b0;
    repeat (n) @(negedge clk_sys);
    check({11'h0, ready, spi_miso_oe, fault_out, mod_pos, mod_neg}, 16'h1);
    reset_n = 1'b1;
    k = 0;
    while (ready !== 1'b1 && k < START + 20) begin
      @(negedge clk_sys);
      k++;
    end
    check(16'(k >= START && k <= START + 4), 16'h1);
  endtask
  // Words before any sample, then a burst that overruns the buffer
  task automatic t_frames;
    rcs_host_model_inst.read_frame(1'b1);
    check(rcs_host_model_inst.frame_reg[39:24], 16'h8000);
    check(rcs_host_model_inst.frame_reg[23:8], 16'h8000);
    check(rcs_host_model_inst.frame_reg[7:0], crc8(rcs_host_model_inst.frame_reg[39:8]));
    meas_valid = 1'b1;
    repeat (20) @(negedge clk_sys);
    meas_valid = 1'b0;
    repeat (10) @(negedge clk_sys);
    rcs_host_model_inst.read_frame(1'b0);
    check(rcs_host_model_inst.frame_reg[39:24], 16'h8000);
    check(rcs_host_model_inst.comp_reg[15:0], 16'h0);
  endtask
  // Test coil current scaled tenfold, then the bitstream density of that word
  task automatic t_stream;
    int ones;
    test_coil_in = 16'sh0666;
    meas_valid = 1'b1;
    repeat (40) @(negedge clk_sys);
    meas_valid = 1'b0;
    rcs_host_model_inst.read_frame(1'b0);
    check(rcs_host_model_inst.frame_reg[39:24], 16'hbffc);
    ones = 0;
    repeat (256) begin
      @(negedge clk_mod);
      ones = ones + int'(mod_pos);
    end
    check(16'(ones >= 190 && ones <= 193), 16'h1);
    test_coil_in = 16'sh0;
  endtask
  task automatic t_toggle;
    logic f;
    int   n;
    for (int p = 0; p < 2; p++) begin
      f = fault_out;
      n = 0;
      while (fault_out === f && n < 6000) begin
        @(negedge clk_sys);
        n++;
      end
    end
    check(16'(n >= 2976 && n <= 5681), 16'h1);
  endtask
  // Self-test comes last since it stays set until reset
  task automatic t_fault;
    logic f;
    for (int k = 0; k < 3; k++) begin
      fault_in = rcs_fault_type'(3'h4 >> k);
      meas_in = 16'sh1234;
      meas_valid = 1'b1;
      // Long enough for the full buffer to shed every older sample
      repeat (40) @(negedge clk_sys);
      meas_valid = 1'b0;
      repeat (20) @(negedge clk_sys);
      f = fault_out;
      rcs_host_model_inst.read_frame(1'b0);
      check(rcs_host_model_inst.frame_reg[39:24], fexp[k]);
      check(rcs_host_model_inst.frame_reg[7:0], crc8(rcs_host_model_inst.frame_reg[39:8]));
      repeat (8000) @(negedge clk_sys);
      check({15'h0, fault_out}, {15'h0, f});
      fault_in = 3'h0;
      meas_in = 16'sh0;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    t_reset(8);
    t_frames;
    t_stream;
    t_toggle;
    t_fault;
    t_reset(625);
    t_toggle;
    results;
  end
  initial begin
    #800000;
    err_count++;
    results;
  end
endmodule
